// ===== perf_sel_pkg.sv
// package of event codes, unit masks and field widths for the event selector
//
// Behaviour
// - CBH/10H counts retired loads missing translation buffer
// - faulting loads never count as misses
// - only cacheable loads, never software prefetch loads
// - precise sample records next instruction address
// - CCH/01H counts first packed-int after float
// - CCH/02H counts first float after packed-int
// - CDH/00H counts empty-state assists changing stack
// - CEH/00H counts retired packed-register instructions
// - CFH/00H counts retired saturating packed instructions
// - D2H/01H counts reorder read-port stall cycles
// - persisting read-port stall counts every retry cycle
// - D2H/02H counts partial-register extra latency cycles
// - D2H/04H counts flag stall cycles
// - partial flag stall needs subset write, unmodified read
// - D2H/08H status-word write adds two
// - D2H/0FH counts any of four stall kinds
package perf_sel_pkg;
    localparam int EVT_W   = 8;
    localparam int MASK_W  = 8;
    localparam int CNT_W   = 48;
    localparam int ADDR_W  = 48;
    localparam int FLAG_W  = 8;
    localparam int INC_W   = 2;

    localparam logic [EVT_W-1:0]  EVT_LOAD_RET   = 8'hCB;
    localparam logic [EVT_W-1:0]  EVT_FP_TRANS   = 8'hCC;
    localparam logic [EVT_W-1:0]  EVT_ASSIST     = 8'hCD;
    localparam logic [EVT_W-1:0]  EVT_PACKED_RET = 8'hCE;
    localparam logic [EVT_W-1:0]  EVT_SAT_RET    = 8'hCF;
    localparam logic [EVT_W-1:0]  EVT_ALLOC_STL  = 8'hD2;

    localparam logic [MASK_W-1:0] UM_NONE        = 8'h00;
    localparam logic [MASK_W-1:0] UM_XLAT_MISS   = 8'h10;
    localparam logic [MASK_W-1:0] UM_TO_PACKED   = 8'h01;
    localparam logic [MASK_W-1:0] UM_TO_FLOAT    = 8'h02;
    localparam logic [MASK_W-1:0] UM_READ_PORT   = 8'h01;
    localparam logic [MASK_W-1:0] UM_PARTIAL     = 8'h02;
    localparam logic [MASK_W-1:0] UM_FLAGS       = 8'h04;
    localparam logic [MASK_W-1:0] UM_STATUS_WR   = 8'h08;
    localparam logic [MASK_W-1:0] UM_ANY_STALL   = 8'h0F;

    localparam logic [INC_W-1:0]  INC_ZERO       = 2'h0;
    localparam logic [INC_W-1:0]  INC_ONE        = 2'h1;
    localparam logic [INC_W-1:0]  INC_STATUS_WR  = 2'h2;
    localparam logic [CNT_W-1:0]  CNT_RESET      = 48'h0000_0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET     = 48'h0000_0000_0000;

    // last execution domain seen, for transition events
    typedef enum logic [1:0] {
        DOM_FLOAT  = 2'b01,
        DOM_PACKED = 2'b10
    } exec_dom_t;
endpackage : perf_sel_pkg

// ===== perf_flag_stall.sv
// partial flag stall qualifier
`timescale 1ns/1ps
module perf_flag_stall (
    input  wire logic                            ref_clk,
    input  wire logic                            rst,
    input  wire logic                            flag_write,
    input  wire logic [perf_sel_pkg::FLAG_W-1:0] flag_write_mask,
    input  wire logic                            flag_read,
    input  wire logic [perf_sel_pkg::FLAG_W-1:0] flag_read_mask,
    input  wire logic                            flag_other_stall,
    output logic                                 flag_stall_hit
);
    logic [perf_sel_pkg::FLAG_W-1:0] untouched;
    logic                            partial_pending;

    ////////////////////////////////////////////////////////////////
    // remember which flags the last flag writer left alone; a full write clears it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            untouched       <= '0;
            partial_pending <= 1'b0;
        end else if (flag_write) begin
            untouched       <= ~flag_write_mask;
            partial_pending <= (flag_write_mask != '0) && (~flag_write_mask != '0);
        end else if (flag_read) begin
            partial_pending <= 1'b0;  // only the next flag reader can be hit
        end
    end

    // a partial stall is possible only when the reader wants a flag left unmodified
    assign flag_stall_hit = flag_other_stall
        || (flag_read && partial_pending && ((flag_read_mask & untouched) != '0));
endmodule : perf_flag_stall

// ===== perf_transition.sv
// float and packed-integer transition detector
`timescale 1ns/1ps
module perf_transition (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic float_instr,
    input  wire logic packed_instr,
    output logic      to_packed,
    output logic      to_float
);
    perf_sel_pkg::exec_dom_t last_dom;

    ////////////////////////////////////////////////////////////////
    // float is assumed after reset, so the first packed op counts as a transition
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            last_dom <= perf_sel_pkg::DOM_FLOAT;
        end else if (packed_instr) begin
            last_dom <= perf_sel_pkg::DOM_PACKED;
        end else if (float_instr) begin
            last_dom <= perf_sel_pkg::DOM_FLOAT;
        end
    end

    assign to_packed = packed_instr && (last_dom == perf_sel_pkg::DOM_FLOAT);
    assign to_float  = float_instr && !packed_instr
                       && (last_dom == perf_sel_pkg::DOM_PACKED);
endmodule : perf_transition

// ===== perf_event_select_decode.sv
// event selection and counting for one performance counter
`timescale 1ns/1ps
module perf_event_select_decode (
    input  wire logic                            ref_clk,
    input  wire logic                            rst,
    input  wire logic [perf_sel_pkg::EVT_W-1:0]  event_code,
    input  wire logic [perf_sel_pkg::MASK_W-1:0] unit_mask,
    input  wire logic                            precise_en,
    input  wire logic                            load_retired,
    input  wire logic                            load_xlat_miss,
    input  wire logic                            load_fault,
    input  wire logic                            load_cacheable,
    input  wire logic                            load_sw_prefetch,
    input  wire logic [perf_sel_pkg::ADDR_W-1:0] next_instr_addr,
    input  wire logic                            float_instr,
    input  wire logic                            packed_instr,
    input  wire logic                            empty_state_exec,
    input  wire logic                            empty_state_changed,
    input  wire logic                            packed_reg_retired,
    input  wire logic                            saturating_retired,
    input  wire logic                            read_port_stall,
    input  wire logic                            partial_reg_stall,
    input  wire logic                            flag_write,
    input  wire logic [perf_sel_pkg::FLAG_W-1:0] flag_write_mask,
    input  wire logic                            flag_read,
    input  wire logic [perf_sel_pkg::FLAG_W-1:0] flag_read_mask,
    input  wire logic                            flag_other_stall,
    input  wire logic                            status_word_write,
    output logic [perf_sel_pkg::CNT_W-1:0]       event_count,
    output logic                                 sample_valid,
    output logic [perf_sel_pkg::ADDR_W-1:0]      sample_addr,
    output logic                                 select_valid
);
    logic                            to_packed;
    logic                            to_float;
    logic                            flag_stall_hit;
    logic                            retired_load_xlat_miss;
    logic [perf_sel_pkg::INC_W-1:0]  next_inc;
    logic                            next_valid;

    // compare programmed code and mask to one encoding
    function automatic logic sel_is(
        input logic [perf_sel_pkg::EVT_W-1:0]  code,
        input logic [perf_sel_pkg::MASK_W-1:0] mask,
        input logic [perf_sel_pkg::EVT_W-1:0]  want_code,
        input logic [perf_sel_pkg::MASK_W-1:0] want_mask
    );
        return (code == want_code) && (mask == want_mask);
    endfunction : sel_is

    // one count for a true event, none otherwise
    function automatic logic [perf_sel_pkg::INC_W-1:0] one_if(input logic hit);
        return hit ? perf_sel_pkg::INC_ONE : perf_sel_pkg::INC_ZERO;
    endfunction : one_if

    ////////////////////////////////////////////////////////////////
    // helper detectors
    perf_transition u_transition (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .float_instr  (float_instr),
        .packed_instr (packed_instr),
        .to_packed    (to_packed),
        .to_float     (to_float)
    );

    perf_flag_stall u_flag_stall (
        .ref_clk          (ref_clk),
        .rst              (rst),
        .flag_write       (flag_write),
        .flag_write_mask  (flag_write_mask),
        .flag_read        (flag_read),
        .flag_read_mask   (flag_read_mask),
        .flag_other_stall (flag_other_stall),
        .flag_stall_hit   (flag_stall_hit)
    );

    ////////////////////////////////////////////////////////////////
    // qualified load miss: faults, uncacheable and prefetch loads never count
    assign retired_load_xlat_miss = load_retired && load_xlat_miss
                                    && !load_fault
                                    && load_cacheable && !load_sw_prefetch;

    // increment select; stall events are levels so each stalled cycle counts
    always_comb begin
        next_inc   = perf_sel_pkg::INC_ZERO;
        next_valid = 1'b1;
        if (sel_is(event_code, unit_mask, perf_sel_pkg::EVT_LOAD_RET,
                   perf_sel_pkg::UM_XLAT_MISS)) begin
            next_inc = one_if(retired_load_xlat_miss);
        end else if (sel_is(event_code, unit_mask, perf_sel_pkg::EVT_FP_TRANS,
                            perf_sel_pkg::UM_TO_PACKED)) begin
            next_inc = one_if(to_packed);
        end else if (sel_is(event_code, unit_mask, perf_sel_pkg::EVT_FP_TRANS,
                            perf_sel_pkg::UM_TO_FLOAT)) begin
            next_inc = one_if(to_float);
        end else if (sel_is(event_code, unit_mask, perf_sel_pkg::EVT_ASSIST,
                            perf_sel_pkg::UM_NONE)) begin
            next_inc = one_if(empty_state_exec && empty_state_changed);
        end else if (sel_is(event_code, unit_mask, perf_sel_pkg::EVT_PACKED_RET,
                            perf_sel_pkg::UM_NONE)) begin
            next_inc = one_if(packed_reg_retired);
        end else if (sel_is(event_code, unit_mask, perf_sel_pkg::EVT_SAT_RET,
                            perf_sel_pkg::UM_NONE)) begin
            next_inc = one_if(saturating_retired);
        end else if (sel_is(event_code, unit_mask, perf_sel_pkg::EVT_ALLOC_STL,
                            perf_sel_pkg::UM_READ_PORT)) begin
            next_inc = one_if(read_port_stall);
        end else if (sel_is(event_code, unit_mask, perf_sel_pkg::EVT_ALLOC_STL,
                            perf_sel_pkg::UM_PARTIAL)) begin
            next_inc = one_if(partial_reg_stall);
        end else if (sel_is(event_code, unit_mask, perf_sel_pkg::EVT_ALLOC_STL,
                            perf_sel_pkg::UM_FLAGS)) begin
            next_inc = one_if(flag_stall_hit);
        end else if (sel_is(event_code, unit_mask, perf_sel_pkg::EVT_ALLOC_STL,
                            perf_sel_pkg::UM_STATUS_WR)) begin
            // two per write, so software halves the count to get writes
            next_inc = status_word_write ? perf_sel_pkg::INC_STATUS_WR
                                         : perf_sel_pkg::INC_ZERO;
        end else if (sel_is(event_code, unit_mask, perf_sel_pkg::EVT_ALLOC_STL,
                            perf_sel_pkg::UM_ANY_STALL)) begin
            // one per cycle however many stall kinds coincide
            next_inc = one_if(read_port_stall || partial_reg_stall
                              || flag_stall_hit || status_word_write);
        end else begin
            next_valid = 1'b0;
        end
    end

    assign select_valid = next_valid;

    ////////////////////////////////////////////////////////////////
    // counter; wraps silently, overflow handling lives elsewhere
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            event_count <= perf_sel_pkg::CNT_RESET;
        end else if (next_valid) begin
            event_count <= event_count + perf_sel_pkg::CNT_W'(next_inc);
        end
    end

    ////////////////////////////////////////////////////////////////
    // precise sample of the load-miss event: the address after the culprit
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sample_valid <= 1'b0;
            sample_addr  <= perf_sel_pkg::ADDR_RESET;
        end else begin
            sample_valid <= 1'b0;
            if (precise_en && retired_load_xlat_miss
                && sel_is(event_code, unit_mask, perf_sel_pkg::EVT_LOAD_RET,
                          perf_sel_pkg::UM_XLAT_MISS)) begin
                sample_valid <= 1'b1;
                sample_addr  <= next_instr_addr;
            end
        end
    end
endmodule : perf_event_select_decode

// ===== pipe_model.sv
// pipeline and retirement side model that launches event pulses
`timescale 1ns/1ps
module pipe_model (
    input  wire logic        ref_clk,
    input  wire logic [16:0] req,
    output logic      [16:0] ev
);
    // quiet until the first falling edge so no input starts unknown
    initial ev = 17'h0_0000;
    // launch on the falling edge: the block samples settled levels on the rising one
    always @(negedge ref_clk) begin
        ev <= req;
    end
endmodule : pipe_model

// ===== perf_sel_monitor.sv
// concurrent checks on the event selector ports
`timescale 1ns/1ps
module perf_sel_monitor (
    input wire logic                            ref_clk,
    input wire logic                            rst,
    input wire logic [perf_sel_pkg::EVT_W-1:0]  event_code,
    input wire logic [perf_sel_pkg::MASK_W-1:0] unit_mask,
    input wire logic                            precise_en,
    input wire logic                            load_retired,
    input wire logic                            load_xlat_miss,
    input wire logic                            load_fault,
    input wire logic                            load_cacheable,
    input wire logic                            load_sw_prefetch,
    input wire logic [perf_sel_pkg::ADDR_W-1:0] next_instr_addr,
    input wire logic                            read_port_stall,
    input wire logic                            status_word_write,
    input wire logic [perf_sel_pkg::CNT_W-1:0]  event_count,
    input wire logic                            sample_valid,
    input wire logic [perf_sel_pkg::ADDR_W-1:0] sample_addr,
    input wire logic                            select_valid
);
    logic [15:0] sel;
    logic        good_miss;
    // a load miss that must count: cacheable, no fault, no prefetch
    assign sel       = {event_code, unit_mask};
    assign good_miss = sel == 16'hCB10 && load_retired && load_xlat_miss && !load_fault
                       && load_cacheable && !load_sw_prefetch;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    property p_reset;
        $fell(rst) |-> event_count == '0 && !sample_valid && sample_addr == '0;
    endproperty
    property p_miss;
        good_miss |=> event_count == $past(event_count) + 1'b1;
    endproperty
    property p_fault;
        sel == 16'hCB10 && load_fault |=> $stable(event_count);
    endproperty
    property p_pref;
        sel == 16'hCB10 && (load_sw_prefetch || !load_cacheable) |=> $stable(event_count);
    endproperty
    property p_sample;
        precise_en && good_miss |=> sample_valid && sample_addr == $past(next_instr_addr);
    endproperty
    property p_unsup;
        !select_valid |=> $stable(event_count);
    endproperty
    property p_status;
        sel == 16'hD208 && status_word_write |=> event_count == $past(event_count) + 2'd2;
    endproperty
    // a stall lasting two cycles must add two, not one
    property p_stall;
        (sel == 16'hD201 && read_port_stall) [*2]
            |=> event_count == $past(event_count, 2) + 2'd2;
    endproperty
    a_reset: assert property (p_reset) else $error("counter not cleared by reset");
    a_miss: assert property (p_miss) else $error("load miss not counted");
    a_fault: assert property (p_fault) else $error("faulting load counted");
    a_pref: assert property (p_pref) else $error("excluded load counted");
    a_sample: assert property (p_sample) else $error("sample address wrong");
    a_unsup: assert property (p_unsup) else $error("unsupported pair counted");
    a_status: assert property (p_status) else $error("status write not two");
    a_stall: assert property (p_stall) else $error("stall cycle missed");
    cover property (good_miss);
    cover property (sel == 16'hD208 && status_word_write);
    cover property (sample_valid);
    cover property (!select_valid && load_retired);
endmodule : perf_sel_monitor

bind perf_event_select_decode perf_sel_monitor u_mon (
    .ref_clk, .rst, .event_code, .unit_mask, .precise_en, .load_retired, .load_xlat_miss,
    .load_fault, .load_cacheable, .load_sw_prefetch, .next_instr_addr, .read_port_stall,
    .status_word_write, .event_count, .sample_valid, .sample_addr, .select_valid
);

// ===== tb_top.sv
// self-checking bench for the event selector
`timescale 1ns/1ps
module tb_top;
    logic                            ref_clk = 1'b0;
    logic                            rst = 1'b1;
    logic [perf_sel_pkg::EVT_W-1:0]  event_code = 8'h00;
    logic [perf_sel_pkg::MASK_W-1:0] unit_mask = 8'h00;
    logic                            precise_en = 1'b1;
    logic [perf_sel_pkg::ADDR_W-1:0] next_instr_addr = 48'h0000_0000_0000;
    logic [perf_sel_pkg::FLAG_W-1:0] flag_write_mask = 8'h00;
    logic [perf_sel_pkg::FLAG_W-1:0] flag_read_mask = 8'h00;
    logic [16:0]                     req = 17'h0_0000;
    logic [16:0]                     ev;
    logic [perf_sel_pkg::CNT_W-1:0]  event_count;
    logic                            sample_valid;
    logic [perf_sel_pkg::ADDR_W-1:0] sample_addr;
    logic                            select_valid;
    logic [perf_sel_pkg::CNT_W-1:0]  base;
    int                              failures = 0;
    int                              checked = 0;
    always #12.5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////
    // event bits: 0 load, 1 miss, 2 fault, 3 cacheable, 4 prefetch, 5 float, 6 packed,
    // 7-8 empty exec/changed, 9 packed reg, 10 sat, 11 read port, 12 partial,
    // 13 flag write, 14 flag read, 15 other flag, 16 status write
    pipe_model model (.ref_clk(ref_clk), .req(req), .ev(ev));
    perf_event_select_decode DUT (
        .ref_clk(ref_clk), .rst(rst), .event_code(event_code), .unit_mask(unit_mask),
        .precise_en(precise_en), .load_retired(ev[0]), .load_xlat_miss(ev[1]),
        .load_fault(ev[2]), .load_cacheable(ev[3]), .load_sw_prefetch(ev[4]),
        .next_instr_addr(next_instr_addr), .float_instr(ev[5]), .packed_instr(ev[6]),
        .empty_state_exec(ev[7]), .empty_state_changed(ev[8]), .packed_reg_retired(ev[9]),
        .saturating_retired(ev[10]), .read_port_stall(ev[11]), .partial_reg_stall(ev[12]),
        .flag_write(ev[13]), .flag_write_mask(flag_write_mask), .flag_read(ev[14]),
        .flag_read_mask(flag_read_mask), .flag_other_stall(ev[15]),
        .status_word_write(ev[16]), .event_count(event_count), .sample_valid(sample_valid),
        .sample_addr(sample_addr), .select_valid(select_valid)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    // select, hold the events for n rising edges, then compare the counter growth
    task automatic run(input logic [15:0] sel, input logic [16:0] e, input int n, input int exp);
        @(negedge ref_clk);
        {event_code, unit_mask} = sel;
        @(negedge ref_clk);
        base = event_count;
        @(posedge ref_clk);
        req = e;
        repeat (n) @(posedge ref_clk);
        req = 17'h0_0000;
        repeat (2) @(negedge ref_clk);
        chk("event_count", base + 48'(exp), event_count);
    endtask : run
    task automatic report_and_stop;
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////
    // one good miss; the sample pulse stands one cycle and only while sampling is on
    task automatic pulse_miss(input logic en);
        @(negedge ref_clk);
        precise_en = en;
        @(posedge ref_clk);
        req = 17'h0_000B;
        @(posedge ref_clk);
        req = 17'h0_0000;
        @(negedge ref_clk);
        chk("sample_valid", {47'h0, en}, {47'h0, sample_valid});
        @(negedge ref_clk);
        chk("sample_valid", 48'h0000_0000_0000, {47'h0, sample_valid});
        precise_en = 1'b1;
    endtask : pulse_miss
    task automatic t_miss;
        next_instr_addr = 48'h0000_00AB_CD00;
        run(16'hCB10, 17'h0_000B, 3, 3);
        chk("sample_addr", 48'h0000_00AB_CD00, sample_addr);
        chk("select_valid", 48'h0000_0000_0001, {47'h0, select_valid});
        pulse_miss(1'b1);
        pulse_miss(1'b0);
        run(16'hCB10, 17'h0_000F, 2, 0);
        run(16'hCB10, 17'h0_001B, 1, 0);
        run(16'hCB10, 17'h0_0003, 1, 0);
    endtask : t_miss
    // history starts as float after reset, so the first packed pulse is a transition
    task automatic t_trans;
        run(16'hCC01, 17'h0_0040, 2, 1);
        run(16'hCC02, 17'h0_0020, 3, 1);
        run(16'hCC01, 17'h0_0040, 1, 1);
    endtask : t_trans
    task automatic t_retire;
        run(16'hCD00, 17'h0_0180, 2, 2);
        run(16'hCD00, 17'h0_0080, 1, 0);
        run(16'hCE00, 17'h0_0200, 3, 3);
        run(16'hCF00, 17'h0_0400, 2, 2);
    endtask : t_retire
    task automatic t_stalls;
        run(16'hD201, 17'h0_0800, 4, 4);
        run(16'hD202, 17'h0_1000, 3, 3);
        run(16'hD204, 17'h0_8000, 2, 2);
        run(16'hD208, 17'h1_0000, 3, 6);
        run(16'hD20F, 17'h1_9800, 2, 2);
        run(16'hD20F, 17'h1_0000, 1, 1);
    endtask : t_stalls
    // partial write then a read of untouched flags stalls; reading written flags does not
    task automatic t_flags;
        flag_write_mask = 8'h0F;
        flag_read_mask  = 8'hF0;
        run(16'hD204, 17'h0_2000, 1, 0);
        run(16'hD204, 17'h0_4000, 1, 1);
        flag_read_mask = 8'h0F;
        run(16'hD204, 17'h0_2000, 1, 0);
        run(16'hD204, 17'h0_4000, 1, 0);
    endtask : t_flags
    task automatic t_unsup;
        run(16'hD210, 17'h1_FFFF, 2, 0);
        chk("select_valid", 48'h0000_0000_0000, {47'h0, select_valid});
        run(16'hCB01, 17'h0_000B, 1, 0);
    endtask : t_unsup
    ////////////////////////////////////////////////////////////////////////////
    // bench models counter zero, the only place software puts the load-miss event
    initial begin
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        t_miss;
        t_trans;
        t_retire;
        t_stalls;
        t_flags;
        t_unsup;
        report_and_stop;
    end
    // the whole sequence needs about 150 cycles; 800 means a hang
    initial begin
        #20000;
        failures++;
        report_and_stop;
    end
endmodule : tb_top
